// ===== core/adder_pkg.sv
package adder_pkg;

	// data path geometry
	localparam int WORD_W = 36; // one adder half
	localparam int HI_W = WORD_W - 32; // bits held in each upper register word
	localparam int UWORD_W = 75; // whole microword, parity included
	localparam int FIELD_W = 6; // adder control field
	localparam int ADDR_W = 8; // decoded bus address bits

	// placement of the adder control field and the long-adder bit in the microword
	localparam int ADF_LSB = 20;
	localparam int LONG_BIT = 60;

	// positions inside the adder control field
	localparam int FLD_CIN = 5; // carry input
	localparam int FLD_MODE = 4; // one selects the boolean set
	localparam int FLD_SEL_LSB = 0; // four-bit function select

	// positions of the function select bits
	localparam int SEL_BIT3 = 3;
	localparam int SEL_BIT2 = 2;
	localparam int SEL_BIT1 = 1;
	localparam int SEL_BIT0 = 0;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_A_MAIN_LO = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_A_MAIN_HI = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_B_MAIN_LO = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_B_MAIN_HI = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_A_EXT_LO = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_A_EXT_HI = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_B_EXT_LO = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_B_EXT_HI = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_UWORD_0 = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_UWORD_1 = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_UWORD_2 = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_RES_MAIN_LO = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_RES_MAIN_HI = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_RES_EXT_LO = 8'h38;
	localparam logic [ADDR_W-1:0] OFS_RES_EXT_HI = 8'h3C;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h40;

	// status register bits
	localparam int ST_COUT_MAIN = 0;
	localparam int ST_COUT_EXT = 1;
	localparam int ST_GEN_MAIN = 2;
	localparam int ST_CARRY_PROPAGATE_TERM_MAIN = 3;
	localparam int ST_LONG = 4;
	localparam int ST_BOOL = 5;
	localparam int ST_W = 6;

	// reset values
	localparam logic [WORD_W-1:0] WORD_RST = 36'h0_0000_0000;
	localparam logic [UWORD_W-1:0] UWORD_RST = 75'h000_0000_0000_0000_0000;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== core/adder_function_control.sv
// Functional notes
// - take a 75-bit microword with parity
// - six-bit field steers both adder halves
// - low four field bits pick sixteen functions
// - mode bit one boolean, zero arithmetic
// - carry input adds one to arithmetic
// - arithmetic codes give A, 2A, A+B, A-B-1, -1, A-1
// - boolean codes give ones, equivalence, xor, B, zeros
// - carry out as from one-bit-wider adder
// - carry out independent of mode bit
// - boolean with carry in still carries out
// - both results formed at once, carries arithmetic
// - per-digit generate and propagate from select terms
// - boolean mode suppresses carries at output
// - 36-bit halves join only under long special
// - arithmetic output is xor with carries
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module adder_function_control
	import adder_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	////////////////////////////////////////////////////////////////////////////////
	// helper functions

	// merge one bus word into an old value under the byte strobes
	function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction

	// same merge for a narrow upper part, which sits in the low lane bits of its word
	function automatic logic [HI_W-1:0] hi_merge(input logic [HI_W-1:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = strb_merge({{(32-HI_W){1'b0}}, old_v}, new_v, strb);
		return res[HI_W-1:0];
	endfunction

	// one adder half: returns {group generate, group propagate, carry out, result}
	function automatic logic [WORD_W+2:0] alu_half(input logic [WORD_W-1:0] a,
		input logic [WORD_W-1:0] b, input logic [3:0] sel, input logic bool_mode,
		input logic cin);
		logic [WORD_W-1:0] bn;
		logic [WORD_W-1:0] gen_t;
		logic [WORD_W-1:0] carry_propagate_term_t;
		logic [WORD_W-1:0] fval;
		logic [WORD_W:0] sum;
		logic [WORD_W:0] sum0;
		logic grp_p;
		bn = ~b;
		// propagate: A ored with select-gated true and complement B
		carry_propagate_term_t = a | (bn & {WORD_W{sel[SEL_BIT3]}}) | (b & {WORD_W{sel[SEL_BIT2]}});
		// generate: A gated by select-steered B terms, so generate implies propagate
		gen_t = a & ((b & {WORD_W{sel[SEL_BIT1]}}) | (bn & {WORD_W{sel[SEL_BIT0]}}));
		// arithmetic function is propagate plus generate, carry entering at bit 0
		sum = {1'b0, carry_propagate_term_t} + {1'b0, gen_t} + {{WORD_W{1'b0}}, cin};
		sum0 = {1'b0, carry_propagate_term_t} + {1'b0, gen_t};
		// boolean result has no carries at all; arithmetic one is the xor chain
		if (bool_mode) begin
			fval = ~(carry_propagate_term_t ^ gen_t);
		end else begin
			fval = sum[WORD_W-1:0];
		end
		// carry and group terms come from the arithmetic sum in both modes
		// group propagate: the carry-free sum is all ones, so a carry in would ripple out
		grp_p = ~sum0[WORD_W] & (&sum0[WORD_W-1:0]);
		return {sum0[WORD_W], grp_p, sum[WORD_W], fval};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// storage

	logic [WORD_W-1:0] a_main_r; // main half A operand
	logic [WORD_W-1:0] b_main_r; // main half B operand
	logic [WORD_W-1:0] a_ext_r; // extension half A operand
	logic [WORD_W-1:0] b_ext_r; // extension half B operand
	localparam int UW_TOP_W = UWORD_W - 64; // microword bits in its third bus word
	logic [UWORD_W-1:0] uword_r; // whole microword as written
	logic [WORD_W-1:0] res_main_r; // registered main result
	logic [WORD_W-1:0] res_ext_r; // registered extension result
	logic [ST_W-1:0] status_r; // registered carries and mode

	// write channel state
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic [ADDR_W-1:0] waddr_r; // captured write address
	logic [31:0] wdata_r; // captured write data
	logic [3:0] wstrb_r; // captured strobes
	logic do_write; // both halves of a write are held and no answer is pending
	logic wmap; // write address is a writable register

	// read channel state
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// decoded microword fields
	logic [FIELD_W-1:0] ad_field; // adder control field
	logic [3:0] fsel; // function select
	logic bool_mode; // boolean set chosen
	logic carry_in; // carry into the least significant bit
	logic long_adder_special; // join halves into one 72-bit adder

	// combinational adder outputs
	logic [WORD_W+2:0] ext_out;
	logic [WORD_W+2:0] main_out;
	logic main_cin;

	////////////////////////////////////////////////////////////////////////////////
	// microword decode

	// the field and the long-adder bit are the only parts of the microword used here
	always_comb begin
		ad_field = uword_r[ADF_LSB +: FIELD_W];
		fsel = ad_field[FLD_SEL_LSB +: 4];
		bool_mode = ad_field[FLD_MODE];
		carry_in = ad_field[FLD_CIN];
		long_adder_special = uword_r[LONG_BIT];
	end

	////////////////////////////////////////////////////////////////////////////////
	// adder halves

	// both halves share one control field; only the carry path differs in long mode
	always_comb begin
		ext_out = alu_half(a_ext_r, b_ext_r, fsel, bool_mode, carry_in);
		// short mode keeps the halves apart, each with the field's carry input
		if (long_adder_special) begin
			main_cin = ext_out[WORD_W];
		end else begin
			main_cin = carry_in;
		end
		main_out = alu_half(a_main_r, b_main_r, fsel, bool_mode, main_cin);
	end

	// results are registered so that reads see a stable snapshot of the current inputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_main_r <= WORD_RST;
			res_ext_r <= WORD_RST;
			status_r <= '0;
		end else begin
			res_main_r <= main_out[WORD_W-1:0];
			res_ext_r <= ext_out[WORD_W-1:0];
			status_r[ST_COUT_MAIN] <= main_out[WORD_W];
			status_r[ST_COUT_EXT] <= ext_out[WORD_W];
			status_r[ST_CARRY_PROPAGATE_TERM_MAIN] <= main_out[WORD_W+1];
			status_r[ST_GEN_MAIN] <= main_out[WORD_W+2];
			status_r[ST_LONG] <= long_adder_special;
			status_r[ST_BOOL] <= bool_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write address and data channels

	// each channel is taken once, in either order, then closed until the answer is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			waddr_r <= '0;
		end else if (awvalid && awready_r) begin
			awready_r <= 1'b0;
			waddr_r <= awaddr;
		end else if (bvalid_r && bready) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_r <= 1'b1;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (wvalid && wready_r) begin
			wready_r <= 1'b0;
			wdata_r <= wdata;
			wstrb_r <= wstrb;
		end else if (bvalid_r && bready) begin
			wready_r <= 1'b1;
		end
	end

	// writable map; result and status words are read only and refuse writes
	always_comb begin
		do_write = !awready_r && !wready_r && !bvalid_r;
		unique case (waddr_r)
			OFS_A_MAIN_LO, OFS_A_MAIN_HI, OFS_B_MAIN_LO, OFS_B_MAIN_HI,
			OFS_A_EXT_LO, OFS_A_EXT_HI, OFS_B_EXT_LO, OFS_B_EXT_HI,
			OFS_UWORD_0, OFS_UWORD_1, OFS_UWORD_2: wmap = 1'b1;
			default: wmap = 1'b0;
		endcase
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r <= wmap ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_r && bready) begin
			bvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// operand registers

	// upper words hold only the bits above 31; the rest of the lane is dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_main_r <= WORD_RST;
			b_main_r <= WORD_RST;
			a_ext_r <= WORD_RST;
			b_ext_r <= WORD_RST;
		end else if (do_write) begin
			unique case (waddr_r)
				OFS_A_MAIN_LO: a_main_r[31:0] <= strb_merge(a_main_r[31:0], wdata_r, wstrb_r);
				OFS_A_MAIN_HI: a_main_r[WORD_W-1:32] <=
					hi_merge(a_main_r[WORD_W-1:32], wdata_r, wstrb_r);
				OFS_B_MAIN_LO: b_main_r[31:0] <= strb_merge(b_main_r[31:0], wdata_r, wstrb_r);
				OFS_B_MAIN_HI: b_main_r[WORD_W-1:32] <=
					hi_merge(b_main_r[WORD_W-1:32], wdata_r, wstrb_r);
				OFS_A_EXT_LO: a_ext_r[31:0] <= strb_merge(a_ext_r[31:0], wdata_r, wstrb_r);
				OFS_A_EXT_HI: a_ext_r[WORD_W-1:32] <=
					hi_merge(a_ext_r[WORD_W-1:32], wdata_r, wstrb_r);
				OFS_B_EXT_LO: b_ext_r[31:0] <= strb_merge(b_ext_r[31:0], wdata_r, wstrb_r);
				OFS_B_EXT_HI: b_ext_r[WORD_W-1:32] <=
					hi_merge(b_ext_r[WORD_W-1:32], wdata_r, wstrb_r);
				default: ; // other words are not operands
			endcase
		end
	end

	// microword in three words; parity bits are stored but not checked here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			uword_r <= UWORD_RST;
		end else if (do_write) begin
			unique case (waddr_r)
				OFS_UWORD_0: uword_r[31:0] <= strb_merge(uword_r[31:0], wdata_r, wstrb_r);
				OFS_UWORD_1: uword_r[63:32] <= strb_merge(uword_r[63:32], wdata_r, wstrb_r);
				OFS_UWORD_2: uword_r[UWORD_W-1:64] <= UW_TOP_W'(strb_merge({21'h0,
					uword_r[UWORD_W-1:64]}, wdata_r, wstrb_r));
				default: ; // other words are not microword
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read channel

	// one read at a time: address taken, data answered on the next edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rresp_r <= RESP_OKAY;
			// narrow words read back in the low bits, the rest as zero
			unique case (araddr)
				OFS_A_MAIN_LO: rdata_r <= a_main_r[31:0];
				OFS_A_MAIN_HI: rdata_r <= {{(32-HI_W){1'b0}}, a_main_r[WORD_W-1:32]};
				OFS_B_MAIN_LO: rdata_r <= b_main_r[31:0];
				OFS_B_MAIN_HI: rdata_r <= {{(32-HI_W){1'b0}}, b_main_r[WORD_W-1:32]};
				OFS_A_EXT_LO: rdata_r <= a_ext_r[31:0];
				OFS_A_EXT_HI: rdata_r <= {{(32-HI_W){1'b0}}, a_ext_r[WORD_W-1:32]};
				OFS_B_EXT_LO: rdata_r <= b_ext_r[31:0];
				OFS_B_EXT_HI: rdata_r <= {{(32-HI_W){1'b0}}, b_ext_r[WORD_W-1:32]};
				OFS_UWORD_0: rdata_r <= uword_r[31:0];
				OFS_UWORD_1: rdata_r <= uword_r[63:32];
				OFS_UWORD_2: rdata_r <= {21'h0, uword_r[UWORD_W-1:64]};
				OFS_RES_MAIN_LO: rdata_r <= res_main_r[31:0];
				OFS_RES_MAIN_HI: rdata_r <= {{(32-HI_W){1'b0}}, res_main_r[WORD_W-1:32]};
				OFS_RES_EXT_LO: rdata_r <= res_ext_r[31:0];
				OFS_RES_EXT_HI: rdata_r <= {{(32-HI_W){1'b0}}, res_ext_r[WORD_W-1:32]};
				OFS_STATUS: rdata_r <= {{(32-ST_W){1'b0}}, status_r};
				default: begin
					// unmapped or misaligned: zero data with an error answer
					rdata_r <= '0;
					rresp_r <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flip-flops

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

endmodule

`default_nettype wire

// ===== tb/adder_props.sv
`timescale 1ns/1ps
`default_nettype none
// bus-side checks of the adder block
module adder_props
	import adder_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////
	// answers stand until the master takes them
	chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response withdrawn");
	chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data withdrawn");
	// fixed read latency, bounded write latency
	chk_r_lat: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	chk_b_lat: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write answer late");
	// one transfer of each kind at a time
	chk_w_single: assert property (bvalid |-> !awready && !wready)
		else $error("write taken before response");
	chk_r_single: assert property (rvalid |-> !arready)
		else $error("read taken before data");
	// results and status are read-only, holes answer with an error
	chk_ro_refuse: assert property (awvalid && awready && wvalid && wready
		&& awaddr >= OFS_RES_MAIN_LO |-> ##[1:2] (bvalid && bresp == RESP_SLVERR))
		else $error("read-only write not refused");
	chk_hole_read: assert property (arvalid && arready && araddr > OFS_STATUS
		|=> rresp == RESP_SLVERR && rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
endmodule
bind adder_function_control adder_props u_props (.aclk, .aresetn, .awaddr, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
	.rdata, .rresp, .rvalid, .rready);
`default_nettype wire

// ===== tb/control_store.sv
`timescale 1ns/1ps
`default_nettype none
// control store stand-in: one microword built around the adder field
module control_store
	import adder_pkg::*;
(
	input wire logic [FIELD_W-1:0] field,
	input wire logic long_sel,
	input wire logic [31:0] noise,
	output logic [31:0] uw_lo,
	output logic [31:0] uw_mid,
	output logic [31:0] uw_hi
);
	logic [UWORD_W-1:0] uw; // whole word, parity included
	// other fields carry noise, so the block must ignore them
	always_comb begin
		uw = {noise[10:0], ~noise, noise};
		uw[ADF_LSB +: FIELD_W] = field;
		uw[LONG_BIT] = long_sel;
	end
	assign uw_lo = uw[31:0];
	assign uw_mid = uw[63:32];
	assign uw_hi = {21'h0, uw[74:64]};
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// random adder work over the register bus
module testbench
	import adder_pkg::*;
;
	localparam logic [31:0] ONES = 32'hFFFF_FFFF;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, lng;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, noise, uw0, uw1, uw2; // uw: microword words
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [FIELD_W-1:0] fld; // adder field for the store
	int err_total, n_checks, seed;
	adder_function_control u_adder_function_control (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	control_store u_control_store (.field(fld), .long_sel(lng), .noise, .uw_lo(uw0),
		.uw_mid(uw1), .uw_hi(uw2));
	// 40 ns bus clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	////////////////////////////////
	task automatic conclude;
		$display("mismatches %0d, checks %0d", err_total, n_checks);
		if (err_total == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// four-state compare, an unknown matches only an unknown in the same bit
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// a wait that ran out ends the run
	task automatic lim(input logic got);
		if (got !== 1'b1) begin
			err_total++;
			conclude();
		end
	endtask
	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er,
		input logic [3:0] st = 4'hF);
		int n;
		logic aw_t, w_t, got;
		logic [1:0] resp;
		@(posedge aclk);
		n = 0;
		awaddr <= ad;
		wdata <= d;
		wstrb <= st;
		{awvalid, wvalid, bready} <= 3'b111;
		do begin
			// settled mid-cycle values are what the coming rising edge samples
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			got = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (aw_t)
				awvalid <= 1'b0;
			if (w_t)
				wvalid <= 1'b0;
			n++;
		end while (!got && n < 64);
		bready <= 1'b0;
		lim(got);
		chk("bresp", {30'h0, resp}, {30'h0, er});
	endtask
	// read, then compare the bits under mask m
	task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er,
		input string nm, input logic [31:0] m = ONES);
		int n;
		logic ar_t, got;
		logic [31:0] dat;
		logic [1:0] resp;
		@(posedge aclk);
		n = 0;
		araddr <= ad;
		{arvalid, rready} <= 2'b11;
		do begin
			// data is taken in the cycle in which rvalid stands
			@(negedge aclk);
			ar_t = arvalid && arready;
			got = rvalid;
			dat = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ar_t)
				arvalid <= 1'b0;
			n++;
		end while (!got && n < 64);
		rready <= 1'b0;
		lim(got);
		chk(nm, dat & m, e);
		chk("rresp", {30'h0, resp}, {30'h0, er});
	endtask
	// reference half: per-bit generate and propagate, then sum or logic
	function automatic logic [36:0] half(input logic [35:0] a, input logic [35:0] b,
		input logic [5:0] f, input logic c);
		logic [35:0] p, g;
		logic [36:0] s;
		p = a | (~b & {36{f[3]}}) | (b & {36{f[2]}});
		g = a & ((b & {36{f[1]}}) | (~b & {36{f[0]}}));
		s = {1'b0, p} + {1'b0, g} + {36'h0, c};
		// carry out is taken from the sum in both modes
		return {s[36], f[4] ? ~(p ^ g) : s[35:0]};
	endfunction
	// named codes worked out from their stated functions, not from generate and propagate
	function automatic logic [36:0] stated(input logic [35:0] a, input logic [35:0] b,
		input logic [5:0] f, input logic c, input logic [36:0] dflt);
		logic [36:0] s;
		s = dflt;
		case (f[3:0])
			4'h0: s = {1'b0, a} + 37'(c);
			4'h3: s = {1'b0, a} + {1'b0, a} + 37'(c);
			4'h6: s = {1'b0, a} + {1'b0, b} + 37'(c);
			4'h9: s = {1'b0, a} + {1'b0, ~b} + 37'(c);
			4'hC: s = {1'b0, 36'hF_FFFF_FFFF} + 37'(c);
			4'hF: s = {1'b0, a} + {1'b0, 36'hF_FFFF_FFFF} + 37'(c);
			default: ;
		endcase
		// the boolean set keeps the arithmetic carry and replaces only the word
		if (f[4]) begin
			case (f[3:0])
				4'h0: s[35:0] = ~a;
				4'h3: s[35:0] = {36{1'b1}};
				4'h6: s[35:0] = ~(a ^ b);
				4'h9: s[35:0] = a ^ b;
				4'hA: s[35:0] = b;
				4'hC: s[35:0] = '0;
				4'hF: s[35:0] = a;
				default: ;
			endcase
		end
		return s;
	endfunction
	// operand with all-ones and all-zeros corners mixed in
	function automatic logic [35:0] pick();
		int r;
		r = $random(seed);
		return r[5] ? {36{r[6]}} : {r[3:0], 32'($random(seed))};
	endfunction
	// one operation: operands, microword, then both halves and the flags
	task automatic op(input logic [5:0] f, input logic l);
		logic [35:0] v[4]; // main a, main b, ext a, ext b
		logic [36:0] x[2]; // main and extension results with carry
		logic [36:0] g0;
		logic [31:0] e;
		logic c; // carry into the main half
		fld <= f;
		lng <= l;
		noise <= $random(seed);
		for (int i = 0; i < 4; i++) begin
			v[i] = pick();
			wr(OFS_A_MAIN_LO + 8'(8 * i), v[i][31:0], RESP_OKAY);
			wr(OFS_A_MAIN_LO + 8'(8 * i + 4), {28'h0, v[i][35:32]}, RESP_OKAY);
		end
		wr(OFS_UWORD_0, uw0, RESP_OKAY);
		wr(OFS_UWORD_1, uw1, RESP_OKAY);
		wr(OFS_UWORD_2, uw2, RESP_OKAY);
		x[1] = stated(v[2], v[3], f, f[5], half(v[2], v[3], f, f[5]));
		c = l ? x[1][36] : f[5];
		x[0] = stated(v[0], v[1], f, c, half(v[0], v[1], f, c));
		g0 = half(v[0], v[1], {2'b00, f[3:0]}, 1'b0);
		for (int i = 0; i < 4; i++) begin
			e = i[0] ? {28'h0, x[i / 2][35:32]} : x[i / 2][31:0];
			rd(OFS_RES_MAIN_LO + 8'(4 * i), e, RESP_OKAY, "result");
		end
		// group propagate: the carry-free sum is all ones with no carry out
		e = {26'h0, f[4], l, ~g0[36] & (&g0[35:0]), g0[36], x[1][36], x[0][36]};
		rd(OFS_STATUS, e, RESP_OKAY, "status");
	endtask
	////////////////////////////////
	initial begin
		seed = 34;
		err_total = 0;
		n_checks = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, lng} = 7'h00;
		{awaddr, araddr, fld, wdata, noise} = '0;
		wstrb = 4'hF;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		// storage and flags come up cleared
		rd(OFS_A_MAIN_LO, 32'h0, RESP_OKAY, "operand after reset");
		rd(OFS_STATUS, 32'h0, RESP_OKAY, "status after reset");
		// results, status, holes and misaligned addresses refuse and store nothing
		wr(OFS_RES_MAIN_LO, ONES, RESP_SLVERR);
		wr(OFS_STATUS, ONES, RESP_SLVERR);
		wr(8'h44, ONES, RESP_SLVERR);
		wr(8'h02, ONES, RESP_SLVERR);
		rd(8'h80, 32'h0, RESP_SLVERR, "hole");
		rd(OFS_RES_MAIN_LO, 32'h0, RESP_OKAY, "result after refusal");
		// byte strobes: only enabled lanes land, also in a narrow upper word
		wr(OFS_A_MAIN_LO, ONES, RESP_OKAY);
		wr(OFS_A_MAIN_LO, 32'h0000_0000, RESP_OKAY, 4'h5);
		rd(OFS_A_MAIN_LO, 32'hFF00_FF00, RESP_OKAY, "strobed low word");
		wr(OFS_A_MAIN_HI, ONES, RESP_OKAY, 4'hE);
		rd(OFS_A_MAIN_HI, 32'h0000_0000, RESP_OKAY, "strobed high word");
		// every field code, short mode then long mode
		for (int k = 0; k < 128; k++)
			op(k[5:0], k[6]);
		conclude();
	end
endmodule
`default_nettype wire
